// File: hdl/vgl_loader.sv
// Guest-state loading sequencer with Wishbone status and control
`timescale 1ns/10ps
// How it works
// - Control zero loaded except extension, reserved, no-write-through and cache-disable bits.
// - Page table base and control four loaded straight from their fields.
// - Debug control seven loaded when enabled, bits 12,15:14 zero, bit 10 one.
// - Debug feature register loaded only when debug-controls load is enabled.
// - Fast syscall registers loaded; 32-bit fields clear upper half.
// - On long-capable cores both extra-segment base registers follow the segment bases.
// - Without feature load, on long-capable cores active from guest control; enable too only with paging on.
// - Perf, page attribute and feature registers loaded only with their entry controls.
// - Model-register list may later overwrite these, not the extra-segment bases.
// - Register list step starts only after loading and structure checks both finish.
// - System management base changes only on return from that mode.
// - Unusable bit loaded; segments fault outside 64-bit mode, local table always.
// - Task register fully loaded; never unusable.
// - Code segment selector, base, limit, L/D/G always; rest only when usable.
// - Other segments: selectors always; base, limit, rights only when usable, except FS and GS base always.
// - Unusable stack segment: base 3:0 cleared, privilege loaded, big bit set.
// - Long-capable: stack/data bases upper half clear; unusable local table canonical.
// - Global and interrupt table registers loaded every entry.
// - Stack, instruction pointers and flags loaded from fields.
// - Extended paging guests get four pointer entries, from memory or fields.
// - Without tagging, invalidate tag zero translations for all contexts and roots.
module vgl_loader #(
  parameter bit LONG_CAPABLE = 1'b1
) (
  input  wire logic                ref_clk,
  input  wire logic                sys_rst,
  input  wire logic                clkEn,
  input  wire logic                wb_cyc_i,
  input  wire logic                wb_stb_i,
  input  wire logic                wb_we_i,
  input  wire logic [7:0]          wb_adr_i,
  input  wire logic [3:0]          wb_sel_i,
  input  wire logic [31:0]         wb_dat_i,
  output logic [31:0]              wb_dat_o,
  output logic                     wb_ack_o,
  input  wire logic                entryStart,
  input  wire vgl_pkg::vgl_guest_t guestFields,
  input  wire vgl_pkg::vgl_ctl_t   entryCtl,
  input  wire logic                chkDone,
  output logic                     memReq,
  output logic [63:0]              memAddr,
  input  wire logic                memAck,
  input  wire logic [63:0]         memData,
  output logic                     invReq,
  output logic [15:0]              invTag,
  input  wire logic                invAck,
  output vgl_pkg::vgl_guest_t      arch,
  output logic [63:0]              fsBaseMsr,
  output logic [63:0]              gsBaseMsr,
  output logic [1:0]               current_privilege,
  output logic [7:0]               segFault,
  output logic                     busy,
  output logic                     loadDone,
  output logic                     msrListGo
);
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_LOAD,
    ST_FETCH,
    ST_INVAL,
    ST_WAITCHK
  } vgl_state_t;

  vgl_state_t                 stateQ;
  vgl_pkg::vgl_seg_t [7:0]    segNext;
  logic [3:0][63:0]           fetched;
  logic                       fetchDone;
  logic                       fetchGo;
  logic                       cap64;
  logic                       cap64Q;
  logic                       swStartQ;
  logic                       doneStickyQ;
  logic                       wbHit;
  logic                       needFetch;
  logic                       needInval;
  logic                       newLma;
  logic                       newPg;
  logic                       extPaging;
  logic                       start;

  assign cap64 = LONG_CAPABLE && cap64Q;
  assign start = entryStart || swStartQ;

  // Mode of the guest being entered, from the fields about to load
  assign newPg     = guestFields.cr0[vgl_pkg::CR0_PG];
  assign newLma    = entryCtl.loadEfer ? guestFields.efer[vgl_pkg::EFER_LMA] : entryCtl.lmGuest;
  assign extPaging = newPg && guestFields.cr4[vgl_pkg::CR4_PAE] && !newLma;
  assign needFetch = extPaging && !entryCtl.nested;
  assign needInval = !entryCtl.vmTagEn;

  // One next-value slice per segment register
  for (genvar i = 0; i < vgl_pkg::NSEG; i++) begin : gSeg
    vgl_seg_load #(
      .IDX (i)
    ) uSeg (
      .cap64 (cap64),
      .fld   (guestFields.seg[i]),
      .cur   (arch.seg[i]),
      .nxt   (segNext[i])
    );
  end

  assign fetchGo = (stateQ == ST_LOAD) && needFetch;

  vgl_ptr_fetch uFetch (
    .ref_clk   (ref_clk),
    .sys_rst   (sys_rst),
    .clkEn     (clkEn),
    .go        (fetchGo),
    .tableBase (guestFields.cr3),
    .memReq    (memReq),
    .memAddr   (memAddr),
    .memAck    (memAck),
    .memData   (memData),
    .entries   (fetched),
    .done      (fetchDone)
  );

  // Invalidation handshake held until the cache side accepts it
  assign invReq = (stateQ == ST_INVAL);
  assign invTag = vgl_pkg::INV_TAG;
  assign busy   = (stateQ != ST_IDLE);
  assign current_privilege    = arch.seg[vgl_pkg::SEG_SS].ar[vgl_pkg::AR_DPL_LO+1 -: 2];

  // Entry sequence; field order is free, the list step waits on checks
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      stateQ    <= ST_IDLE;
      loadDone  <= 1'b0;
      msrListGo <= 1'b0;
    end else if (clkEn) begin
      loadDone  <= 1'b0;
      msrListGo <= 1'b0;
      unique case (stateQ)
        ST_IDLE: begin
          if (start) begin
            stateQ <= ST_LOAD;
          end
        end
        ST_LOAD: begin
          if (needFetch) begin
            stateQ <= ST_FETCH;
          end else if (needInval) begin
            stateQ <= ST_INVAL;
          end else begin
            stateQ <= ST_WAITCHK;
          end
        end
        ST_FETCH: begin
          if (fetchDone) begin
            stateQ <= needInval ? ST_INVAL : ST_WAITCHK;
          end
        end
        ST_INVAL: begin
          if (invAck) begin
            stateQ <= ST_WAITCHK;
          end
        end
        ST_WAITCHK: begin
          if (chkDone) begin
            stateQ    <= ST_IDLE;
            loadDone  <= 1'b1;
            msrListGo <= 1'b1;
          end
        end
      endcase
    end
  end

  // Control, debug and model registers, all written in the load cycle
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      arch.cr0      <= '0;
      arch.cr3      <= '0;
      arch.cr4      <= '0;
      arch.dr7      <= '0;
      arch.dbgCtl   <= '0;
      arch.sysSeg   <= '0;
      arch.sysStack <= '0;
      arch.sysEntry <= '0;
      arch.perf     <= '0;
      arch.pat      <= '0;
      arch.efer     <= '0;
      arch.sysmgmt_base_reg   <= '0;
    end else if (clkEn && stateQ == ST_LOAD) begin
      arch.cr0 <= (arch.cr0 & vgl_pkg::CR0_KEEP) | (guestFields.cr0 & ~vgl_pkg::CR0_KEEP);
      arch.cr3 <= guestFields.cr3;
      arch.cr4 <= guestFields.cr4;
      if (entryCtl.loadDbg) begin
        arch.dr7    <= (guestFields.dr7 & ~vgl_pkg::DR7_ZERO) | vgl_pkg::DR7_ONE;
        arch.dbgCtl <= guestFields.dbgCtl;
      end
      arch.sysSeg   <= {32'h0000_0000, guestFields.sysSeg[31:0]};
      arch.sysStack <= cap64 ? guestFields.sysStack : {32'h0000_0000, guestFields.sysStack[31:0]};
      arch.sysEntry <= cap64 ? guestFields.sysEntry : {32'h0000_0000, guestFields.sysEntry[31:0]};
      if (entryCtl.loadPerf) begin
        arch.perf <= guestFields.perf;
      end
      if (entryCtl.loadPat) begin
        arch.pat <= guestFields.pat;
      end
      if (entryCtl.loadEfer) begin
        arch.efer <= guestFields.efer;
      end else if (cap64) begin
        arch.efer[vgl_pkg::EFER_LMA] <= entryCtl.lmGuest;
        if (newPg) begin
          arch.efer[vgl_pkg::EFER_LME] <= entryCtl.lmGuest;
        end
      end
      if (entryCtl.smmReturn) begin
        arch.sysmgmt_base_reg <= guestFields.sysmgmt_base_reg;
      end
    end
  end

  // Segment, table, pointer and flag registers
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      arch.seg      <= '0;
      arch.gdtBase  <= '0;
      arch.gdtLimit <= '0;
      arch.idtBase  <= '0;
      arch.idtLimit <= '0;
      arch.rsp      <= '0;
      arch.instruction_pointer      <= '0;
      arch.flags_reg   <= '0;
    end else if (clkEn && stateQ == ST_LOAD) begin
      arch.seg      <= segNext;
      arch.gdtBase  <= guestFields.gdtBase;
      arch.gdtLimit <= guestFields.gdtLimit;
      arch.idtBase  <= guestFields.idtBase;
      arch.idtLimit <= guestFields.idtLimit;
      // Full width kept; upper half is simply unused outside 64-bit mode
      arch.rsp    <= guestFields.rsp;
      arch.instruction_pointer    <= guestFields.instruction_pointer;
      arch.flags_reg <= guestFields.flags_reg;
    end
  end

  // Directory-pointer entries from fields or from the memory walk
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      arch.ptr <= '0;
    end else if (clkEn) begin
      if (stateQ == ST_LOAD && extPaging && entryCtl.nested) begin
        arch.ptr <= guestFields.ptr;
      end else if (stateQ == ST_FETCH && fetchDone) begin
        arch.ptr <= fetched;
      end
    end
  end

  // Extra-segment base registers mirror the loaded segment bases
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      fsBaseMsr <= '0;
      gsBaseMsr <= '0;
    end else if (clkEn && stateQ == ST_LOAD && cap64) begin
      fsBaseMsr <= guestFields.seg[vgl_pkg::SEG_FS].base;
      gsBaseMsr <= guestFields.seg[vgl_pkg::SEG_GS].base;
    end
  end

  // Fault-on-use flags for unusable segments
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      segFault <= 8'h00;
    end else if (clkEn && stateQ == ST_LOAD) begin
      for (int s = 0; s < vgl_pkg::NSEG; s++) begin
        if (s == vgl_pkg::SEG_LDT) begin
          segFault[s] <= segNext[s].ar[vgl_pkg::AR_UNUSE];
        end else begin
          segFault[s] <= segNext[s].ar[vgl_pkg::AR_UNUSE] &&
                         !(newLma && segNext[vgl_pkg::SEG_CS].ar[vgl_pkg::AR_L]);
        end
      end
    end
  end

  // Wishbone slave: one wait state, every address acknowledged
  assign wbHit = wb_cyc_i && wb_stb_i && !wb_ack_o;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      wb_ack_o <= 1'b0;
    end else if (clkEn) begin
      wb_ack_o <= wbHit;
    end
  end

  // Control register; start bit self-clears after one cycle
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      swStartQ <= 1'b0;
      cap64Q   <= vgl_pkg::CAP64_RST;
    end else if (clkEn) begin
      swStartQ <= 1'b0;
      if (wbHit && wb_we_i && wb_adr_i == vgl_pkg::OFF_CTRL && wb_sel_i[0]) begin
        swStartQ <= wb_dat_i[vgl_pkg::CTRL_START] && (stateQ == ST_IDLE);
        cap64Q   <= wb_dat_i[vgl_pkg::CTRL_CAP64];
      end
    end
  end

  // Sticky done flag, write one to clear; a new completion wins
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      doneStickyQ <= 1'b0;
    end else if (clkEn) begin
      if (stateQ == ST_WAITCHK && chkDone) begin
        doneStickyQ <= 1'b1;
      end else if (wbHit && wb_we_i && wb_adr_i == vgl_pkg::OFF_STAT && wb_sel_i[0] &&
                   wb_dat_i[vgl_pkg::STAT_DONE]) begin
        doneStickyQ <= 1'b0;
      end
    end
  end

  // Read data registered with the acknowledge; unmapped reads zero
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (clkEn && wbHit) begin
      unique case (wb_adr_i)
        vgl_pkg::OFF_CTRL: wb_dat_o <= {30'h0, cap64Q, 1'b0};
        vgl_pkg::OFF_STAT: wb_dat_o <= {30'h0, doneStickyQ, busy};
        vgl_pkg::OFF_CR0:  wb_dat_o <= arch.cr0[31:0];
        vgl_pkg::OFF_CR3:  wb_dat_o <= arch.cr3[31:0];
        vgl_pkg::OFF_CR4:  wb_dat_o <= arch.cr4[31:0];
        vgl_pkg::OFF_EFER: wb_dat_o <= arch.efer[31:0];
        vgl_pkg::OFF_DR7:  wb_dat_o <= arch.dr7[31:0];
        default:           wb_dat_o <= 32'h0000_0000;
      endcase
    end
  end
endmodule

// File: hdl/vgl_pkg.sv
// Shared constants and types for the guest-state loader
package vgl_pkg;
  // Segment slots
  localparam int SEG_ES  = 0;
  localparam int SEG_CS  = 1;
  localparam int SEG_SS  = 2;
  localparam int SEG_DS  = 3;
  localparam int SEG_FS  = 4;
  localparam int SEG_GS  = 5;
  localparam int SEG_LDT = 6;
  localparam int SEG_TR  = 7;
  localparam int NSEG    = 8;
  localparam int NPTR    = 4;
  // Access-rights field positions
  localparam int AR_DPL_LO = 5;
  localparam int AR_L      = 13;
  localparam int AR_DB     = 14;
  localparam int AR_G      = 15;
  localparam int AR_UNUSE  = 16;
  // Control register fields and masks
  localparam logic [63:0] CR0_KEEP = 64'h0000_0000_7FFA_FFD0;
  localparam int CR0_PG   = 31;
  localparam int CR4_PAE  = 5;
  localparam int EFER_LME = 8;
  localparam int EFER_LMA = 10;
  localparam logic [63:0] DR7_ZERO = 64'h0000_0000_0000_D000;
  localparam logic [63:0] DR7_ONE  = 64'h0000_0000_0000_0400;
  localparam logic [15:0] INV_TAG  = 16'h0000;
  // Register offsets (byte addresses)
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STAT = 8'h04;
  localparam logic [7:0] OFF_CR0  = 8'h08;
  localparam logic [7:0] OFF_CR3  = 8'h0C;
  localparam logic [7:0] OFF_CR4  = 8'h10;
  localparam logic [7:0] OFF_EFER = 8'h14;
  localparam logic [7:0] OFF_DR7  = 8'h18;
  localparam int CTRL_START = 0;
  localparam int CTRL_CAP64 = 1;
  localparam int STAT_BUSY  = 0;
  localparam int STAT_DONE  = 1;
  localparam logic CAP64_RST = 1'b1;

  typedef struct packed {
    logic [15:0] sel;
    logic [63:0] base;
    logic [31:0] limit;
    logic [31:0] ar;
  } vgl_seg_t;

  typedef struct packed {
    logic [63:0]                 cr0;
    logic [63:0]                 cr3;
    logic [63:0]                 cr4;
    logic [63:0]                 dr7;
    logic [63:0]                 dbgCtl;
    logic [63:0]                 sysSeg;
    logic [63:0]                 sysStack;
    logic [63:0]                 sysEntry;
    logic [63:0]                 perf;
    logic [63:0]                 pat;
    logic [63:0]                 efer;
    vgl_seg_t [NSEG-1:0]         seg;
    logic [63:0]                 gdtBase;
    logic [31:0]                 gdtLimit;
    logic [63:0]                 idtBase;
    logic [31:0]                 idtLimit;
    logic [63:0]                 rsp;
    logic [63:0]                 instruction_pointer;
    logic [63:0]                 flags_reg;
    logic [NPTR-1:0][63:0]       ptr;
    logic [31:0]                 sysmgmt_base_reg;
  } vgl_guest_t;

  typedef struct packed {
    logic loadDbg;
    logic loadEfer;
    logic loadPerf;
    logic loadPat;
    logic lmGuest;
    logic nested;
    logic vmTagEn;
    logic smmReturn;
  } vgl_ctl_t;
endpackage

// File: hdl/vgl_seg_load.sv
// Next-value logic for one segment or table register on entry
`timescale 1ns/10ps
module vgl_seg_load #(
  parameter int IDX = 0
) (
  input  wire logic              cap64,
  input  wire vgl_pkg::vgl_seg_t fld,
  input  wire vgl_pkg::vgl_seg_t cur,
  output vgl_pkg::vgl_seg_t      nxt
);
  // Unusable parts keep their old value, a legal pick for undefined
  always_comb begin
    nxt = cur;
    nxt.sel = fld.sel;
    if (!fld.ar[vgl_pkg::AR_UNUSE] || IDX == vgl_pkg::SEG_TR) begin
      nxt.base  = fld.base;
      nxt.limit = fld.limit;
      nxt.ar    = fld.ar;
      if (IDX == vgl_pkg::SEG_TR) begin
        nxt.ar[vgl_pkg::AR_UNUSE] = 1'b0;
      end
    end else begin
      nxt.ar[vgl_pkg::AR_UNUSE] = 1'b1;
      if (IDX == vgl_pkg::SEG_CS) begin
        nxt.base  = fld.base;
        nxt.limit = fld.limit;
        nxt.ar[vgl_pkg::AR_L]  = fld.ar[vgl_pkg::AR_L];
        nxt.ar[vgl_pkg::AR_DB] = fld.ar[vgl_pkg::AR_DB];
        nxt.ar[vgl_pkg::AR_G]  = fld.ar[vgl_pkg::AR_G];
      end
      if (IDX == vgl_pkg::SEG_SS) begin
        nxt.base[3:0] = 4'h0;
        nxt.ar[vgl_pkg::AR_DPL_LO+1 -: 2] = fld.ar[vgl_pkg::AR_DPL_LO+1 -: 2];
        nxt.ar[vgl_pkg::AR_DB] = 1'b1;
      end
      if (IDX == vgl_pkg::SEG_FS || IDX == vgl_pkg::SEG_GS) begin
        nxt.base = fld.base;
      end
      if (IDX == vgl_pkg::SEG_LDT && cap64) begin
        nxt.base = 64'h0000_0000_0000_0000;
      end
    end
    // Upper base half of ES, SS and DS dropped on long-capable cores
    if (cap64 && (IDX == vgl_pkg::SEG_SS || IDX == vgl_pkg::SEG_DS || IDX == vgl_pkg::SEG_ES)) begin
      nxt.base[63:32] = 32'h0000_0000;
    end
  end
endmodule

// File: hdl/vgl_ptr_fetch.sv
// Reads the four directory-pointer entries from memory
`timescale 1ns/10ps
module vgl_ptr_fetch (
  input  wire logic        ref_clk,
  input  wire logic        sys_rst,
  input  wire logic        clkEn,
  input  wire logic        go,
  input  wire logic [63:0] tableBase,
  output logic             memReq,
  output logic [63:0]      memAddr,
  input  wire logic        memAck,
  input  wire logic [63:0] memData,
  output logic [3:0][63:0] entries,
  output logic             done
);
  logic       activeQ;
  logic [1:0] idxQ;

  // Table is 32-byte aligned, entries 8 bytes apart
  assign memReq  = activeQ;
  assign memAddr = {tableBase[63:5], idxQ, 3'h0};

  // Walk the four entries, one request each
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      activeQ <= 1'b0;
      idxQ    <= 2'h0;
      done    <= 1'b0;
      entries <= '0;
    end else if (clkEn) begin
      done <= 1'b0;
      if (go && !activeQ) begin
        activeQ <= 1'b1;
        idxQ    <= 2'h0;
      end else if (activeQ && memAck) begin
        entries[idxQ] <= memData;
        idxQ <= idxQ + 2'h1;
        if (idxQ == 2'h3) begin
          activeQ <= 1'b0;
          done    <= 1'b1;
        end
      end
    end
  end
endmodule

// File: tb/vgl_loader_asserts.sv
// Port-level checker for the guest-state loader
`timescale 1ns/10ps
module vgl_loader_chk (
  input wire logic                ref_clk,
  input wire logic                sys_rst,
  input wire logic                entryStart,
  input wire vgl_pkg::vgl_guest_t guestFields,
  input wire vgl_pkg::vgl_ctl_t   entryCtl,
  input wire logic                chkDone,
  input wire logic                memReq,
  input wire logic [63:0]         memAddr,
  input wire logic                invReq,
  input wire logic [15:0]         invTag,
  input wire logic                invAck,
  input wire vgl_pkg::vgl_guest_t arch,
  input wire logic [1:0]          current_privilege,
  input wire logic                busy,
  input wire logic                loadDone,
  input wire logic                msrListGo
);
  localparam int SS = vgl_pkg::SEG_SS;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  // Request taken while idle, loader goes busy next cycle
  sequence s_accept;
    !busy && entryStart ##1 busy;
  endsequence
  // Entry whose state must not touch the management base
  sequence s_plain_entry;
    s_accept ##0 !entryCtl.smmReturn;
  endsequence
  a_list_with_done: assert property (loadDone == msrListGo)
    else $error("list start not aligned with done");
  a_list_after_chk: assert property (loadDone |-> $past(chkDone))
    else $error("list start before checks finished");
  a_done_after_all: assert property (loadDone |-> !memReq && !invReq)
    else $error("done while fetch or invalidate pending");
  a_inv_tag_zero: assert property (invReq |-> invTag == 16'h0000)
    else $error("invalidate tag not zero");
  a_inv_holds: assert property (invReq && !invAck |=> invReq)
    else $error("invalidate dropped before ack");
  a_cr0_kept: assert property ($stable(arch.cr0 & vgl_pkg::CR0_KEEP))
    else $error("protected control zero bits changed");
  a_dr7_forced: assert property (loadDone && entryCtl.loadDbg |->
    arch.dr7[15:14] == 2'b00 && !arch.dr7[12] && arch.dr7[10]) else $error("debug seven fixed bits wrong");
  a_cr34_direct: assert property (loadDone |->
    arch.cr3 == guestFields.cr3 && arch.cr4 == guestFields.cr4) else $error("cr3 or cr4 not loaded");
  a_sysmgmt_base_reg_kept: assert property (s_plain_entry |=> $stable(arch.sysmgmt_base_reg))
    else $error("management base changed");
  a_ss_unusable: assert property (loadDone && guestFields.seg[SS].ar[16] |->
    arch.seg[SS].ar[14] && arch.seg[SS].base[3:0] == 4'h0) else $error("unusable stack seg wrong");
  a_cpl_ss: assert property (loadDone |-> current_privilege == guestFields.seg[SS].ar[6:5])
    else $error("privilege not from stack seg");
  a_fetch_base: assert property (memReq |->
    memAddr[63:5] == arch.cr3[63:5] && memAddr[2:0] == 3'h0) else $error("pointer fetch address wrong");
endmodule

// File: tb/vgl_loader_tb.sv
// Self-checking bench for the guest-state loader
`timescale 1ns/10ps
module vgl_loader_tb;
  localparam logic [63:0] ONES = 64'hFFFF_FFFF_FFFF_FFFF;
  localparam int          SSI = vgl_pkg::SEG_SS;
  localparam int          DSI = vgl_pkg::SEG_DS;
  localparam int          LDI = vgl_pkg::SEG_LDT;
  logic                   ref_clk = 1'b0;
  logic                   sys_rst = 1'b1;
  logic                   wbCyc = 1'b0, wbStb = 1'b0, wbWe = 1'b0, wbAck;
  logic [7:0]             wbAdr = 8'h00;
  logic [31:0]            wbDin = 32'h0, wbDout, rd;
  logic                   entryStart = 1'b0, chkDone = 1'b0, memAck = 1'b0, invAck = 1'b0;
  logic                   memReq, invReq, busy, loadDone, msrListGo;
  logic [63:0]            memData = 64'h0, memAddr, fsBaseMsr, gsBaseMsr;
  logic [15:0]            invTag;
  logic [1:0]             current_privilege;
  logic [7:0]             segFault;
  vgl_pkg::vgl_guest_t    guestFields = '0, g = '0, arch;
  vgl_pkg::vgl_ctl_t      entryCtl = '0, c = '0;
  int                     err_total = 0, checks_done = 0;

  vgl_loader dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .clkEn(1'b1), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb),
    .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(4'hF), .wb_dat_i(wbDin), .wb_dat_o(wbDout), .wb_ack_o(wbAck),
    .entryStart(entryStart), .guestFields(guestFields), .entryCtl(entryCtl), .chkDone(chkDone),
    .memReq(memReq), .memAddr(memAddr), .memAck(memAck), .memData(memData), .invReq(invReq),
    .invTag(invTag), .invAck(invAck), .arch(arch), .fsBaseMsr(fsBaseMsr), .gsBaseMsr(gsBaseMsr),
    .current_privilege(current_privilege), .segFault(segFault), .busy(busy), .loadDone(loadDone), .msrListGo(msrListGo));

  // Free-running 100 MHz clock
  initial forever #5 ref_clk = ~ref_clk;

  task chk(input logic [63:0] seen, input logic [63:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task finish_test;
    $display("checks_done=%0d err_total=%0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // One classic Wishbone cycle; held until ack is sampled
  task wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge ref_clk);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbAdr <= a;
    wbDin <= d;
    for (i = 0; i < 20; i++) begin
      @(posedge ref_clk);
      if (wbAck === 1'b1) break;
    end
    if (i == 20) begin
      err_total++;
      finish_test();
    end
    rd = wbDout;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
  endtask

  // Launch an entry, serve memory and invalidate, release checks late
  task entry(input int chkDly, input int nMem, input logic inv);
    int i;
    int nAck;
    int nInv;
    nAck = 0;
    nInv = 0;
    @(posedge ref_clk);
    guestFields <= g;
    entryCtl <= c;
    entryStart <= 1'b1;
    @(posedge ref_clk);
    entryStart <= 1'b0;
    for (i = 0; i < 300; i++) begin
      @(negedge ref_clk);
      if (loadDone === 1'b1) break;
      nAck += int'(memReq & memAck);
      nInv += int'(invReq);
      @(posedge ref_clk);
      memAck <= memReq & ~memAck;
      memData <= 64'hC0DE_0000_0000_0000 | memAddr[4:3];
      invAck <= invReq & ~invAck;
      chkDone <= (i >= chkDly);
    end
    if (i == 300) begin
      err_total++;
      finish_test();
    end
    chk(i > chkDly, 1'b1);
    chk(nAck, nMem);
    chk(nInv != 0, inv);
    @(posedge ref_clk);
    chkDone <= 1'b0;
  endtask

  // Long-mode guest, control zero, syscall, debug, perf and stack fields busy with ones
  task s_base;
    g = '0;
    g.cr0 = ONES;
    g.cr3 = 64'h0000_0001_2345_6000;
    g.cr4 = 64'h0000_0000_0000_0020;
    g.sysSeg = ONES;
    g.sysStack = ONES;
    g.dbgCtl = ONES;
    g.perf = ONES;
    g.gdtBase = 64'h0000_7777_0000_1000;
    g.rsp = ONES;
    g.sysmgmt_base_reg = 32'h000A_0000;
    for (int i = 0; i < vgl_pkg::NSEG; i++) begin
      g.seg[i].sel = 16'h0100 | i;
      g.seg[i].base = 64'hABCD_0000_0000_1000 | i;
      g.seg[i].ar = 32'h0000_0093;
    end
    c = '0;
    c.lmGuest = 1'b1;
    c.vmTagEn = 1'b1;
    entry(3, 0, 1'b0);
    chk(arch.cr0, ~vgl_pkg::CR0_KEEP);
    chk(arch.cr3, g.cr3);
    chk(arch.sysSeg, 64'h0000_0000_FFFF_FFFF);
    chk(arch.sysStack, ONES);
    chk(arch.dbgCtl, 64'h0);
    chk(arch.perf, 64'h0);
    chk({arch.efer[10], arch.efer[8]}, 2'b11);
    chk(fsBaseMsr, 64'hABCD_0000_0000_1004);
    chk(gsBaseMsr, 64'hABCD_0000_0000_1005);
    chk(arch.seg[DSI].base, 64'h0000_0000_0000_1003);
    chk(arch.seg[vgl_pkg::SEG_TR].base, g.seg[vgl_pkg::SEG_TR].base);
    chk(arch.gdtBase, g.gdtBase);
    chk(arch.rsp, ONES);
    chk(arch.sysmgmt_base_reg, 32'h0);
  endtask

  // Paging off, unusable segments, tagging off
  task s_unusable;
    g.cr0 = 64'h0;
    for (int i = 0; i < vgl_pkg::NSEG; i++) g.seg[i].sel = 16'h0200 | i;
    g.seg[SSI].ar = 32'h0001_0060;
    g.seg[SSI].base = 64'hFFFF_FFFF_1234_567F;
    g.seg[DSI].ar = 32'h0001_0000;
    g.seg[LDI].ar = 32'h0001_0000;
    g.seg[vgl_pkg::SEG_CS].ar = 32'h0001_E000;
    c = '0;
    entry(2, 0, 1'b1);
    chk({arch.efer[10], arch.efer[8]}, 2'b01);
    chk(current_privilege, 2'h3);
    chk(arch.seg[SSI].ar[14], 1'b1);
    chk(arch.seg[SSI].base[3:0], 4'h0);
    chk(arch.seg[SSI].base[63:32], 32'h0);
    chk(arch.seg[LDI].base, 64'h0);
    chk(arch.seg[vgl_pkg::SEG_CS].ar[15:13], 3'h7);
    chk(arch.seg[DSI].sel, 16'h0203);
    chk(segFault[LDI:DSI], 4'h9);
    chk(segFault[0], 1'b0);
  endtask

  // Extended-address paging: pointers from memory, then from fields
  task s_ptr;
    g.cr0 = 64'h0000_0000_8000_0001;
    g.dr7 = 64'h0000_0000_0000_F000;
    g.efer = 64'h0000_0000_0000_0901;
    for (int i = 0; i < vgl_pkg::NPTR; i++) g.ptr[i] = 64'h5000 | i;
    c = '0;
    c.vmTagEn = 1'b1;
    entry(0, 4, 1'b0);
    for (int i = 0; i < vgl_pkg::NPTR; i++) chk(arch.ptr[i], 64'hC0DE_0000_0000_0000 | i);
    chk(arch.efer[8], 1'b0);
    c = 8'hFF;
    c.lmGuest = 1'b0;
    entry(1, 0, 1'b0);
    for (int i = 0; i < vgl_pkg::NPTR; i++) chk(arch.ptr[i], g.ptr[i]);
    chk(arch.dr7, 64'h0000_0000_0000_2400);
    chk(arch.dbgCtl, ONES);
    chk(arch.perf, ONES);
    chk(arch.efer, g.efer);
    chk(arch.sysmgmt_base_reg, 32'h000A_0000);
  endtask

  // Status, mirror and unmapped reads over the bus
  task s_bus;
    wb(1'b0, vgl_pkg::OFF_STAT, 32'h0);
    chk(rd, 32'h2);
    wb(1'b1, vgl_pkg::OFF_STAT, 32'h2);
    wb(1'b0, vgl_pkg::OFF_STAT, 32'h0);
    chk(rd, 32'h0);
    wb(1'b0, vgl_pkg::OFF_CR3, 32'h0);
    chk(rd, g.cr3[31:0]);
    wb(1'b0, vgl_pkg::OFF_CTRL, 32'h0);
    chk(rd, 32'h2);
    wb(1'b0, 8'h40, 32'h0);
    chk(rd, 32'h0);
    // Software start: busy while waiting on checks, then sticky done
    chkDone <= 1'b1;
    wb(1'b1, vgl_pkg::OFF_CTRL, 32'h3);
    wb(1'b0, vgl_pkg::OFF_STAT, 32'h0);
    chk(rd, 32'h1);
    wb(1'b0, vgl_pkg::OFF_STAT, 32'h0);
    chk(rd, 32'h2);
    chkDone <= 1'b0;
  endtask

  // Reset for six cycles, then the scenarios in turn
  initial begin
    repeat (6) @(posedge ref_clk);
    sys_rst <= 1'b0;
    s_base();
    s_unusable();
    s_ptr();
    s_bus();
    finish_test();
  end
endmodule

bind vgl_loader vgl_loader_chk u_chk (.ref_clk(ref_clk), .sys_rst(sys_rst), .entryStart(entryStart),
  .guestFields(guestFields), .entryCtl(entryCtl), .chkDone(chkDone), .memReq(memReq), .memAddr(memAddr),
  .invReq(invReq), .invTag(invTag), .invAck(invAck), .arch(arch), .current_privilege(current_privilege), .busy(busy),
  .loadDone(loadDone), .msrListGo(msrListGo));
